// ===== dv/plr_process_model.sv
`default_nettype none
module plr_process_model (
  // Clock and reset
  input  wire logic               clock_i,
  input  wire logic               sys_rst_i,
  // Bench control, slew 0 means instant
  input  wire logic signed [15:0] target_i,
  input  wire logic [7:0]         slew_i,
  // Sensor output
  output logic signed [15:0]      feedback_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [16:0] diff;
  assign diff = target_i - feedback_o;
  // Own sensor channel, never the reference input
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || slew_i == 8'h00 || (diff <= $signed({9'h0, slew_i}) && diff >= -$signed({9'h0, slew_i}))) begin
      feedback_o <= target_i;
    end else if (diff > 0) begin
      feedback_o <= feedback_o + $signed({8'h0, slew_i});
    end else begin
      feedback_o <= feedback_o - $signed({8'h0, slew_i});
    end
  end
endmodule
`default_nettype wire

// ===== dv/plr_top_tb_top.sv
`default_nettype none
module plr_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'b0, sys_rst_i = 1'b1, run_i = 1'b0;
  logic [2:0] application_mode_i;
  logic [3:0] reference_source_select_i, display_unit_select_i, display_unit_o;
  logic signed [15:0] keypad_reference_value_i, external_reference_i, target, feedback_i;
  logic [7:0] slew;
  logic [13:0] loop_proportional_gain_i, alternate_gain_value_i, feed_forward_gain_i;
  logic [13:0] output_lowpass_setting_i, output_scale_factor_i, prestart_fail_delay_i, sleep_entry_delay_i;
  logic [9:0] proportional_gain_scale_i, loop_derivative_time_i;
  logic [8:0] loop_integral_time_i;
  logic [15:0] output_upper_limit_i, output_lower_limit_i, maximum_output_frequency_i, prestart_frequency_i;
  logic [15:0] prestart_exit_level_i, sleep_entry_frequency_i, wake_threshold_i, display_unit_gain_i;
  logic [1:0] wake_criterion_select_i, display_unit_scale_i;
  logic [10:0] terminal_i;
  logic [65:0] terminal_function_assign_i = {48'h0, 6'h17, 6'h16, 6'h15};
  logic [15:0] frequency_command_o;
  logic regulating_o, sleeping_o, prestart_failure_trip_o;
  logic signed [31:0] display_output_o;
  int failures = 0, checked = 0;
  logic signed [15:0] fb_sleep [3] = '{16'sh1388, 16'sh07D0, 16'sh1388};
  logic signed [15:0] fb_wake [3] = '{16'sh07D0, 16'sh0FA0, 16'sh03E8};

  always #20 clock_i = ~clock_i;

  plr_process_model u_proc (.clock_i, .sys_rst_i, .target_i(target), .slew_i(slew), .feedback_o(feedback_i));

  plr_top #(.NTERM(11), .TICK_CYC(25)) dut (
    .clock_i, .sys_rst_i, .run_i, .application_mode_i, .reference_source_select_i, .keypad_reference_value_i,
    .external_reference_i, .feedback_i, .loop_proportional_gain_i, .proportional_gain_scale_i,
    .alternate_gain_value_i, .loop_integral_time_i, .loop_derivative_time_i, .feed_forward_gain_i,
    .output_lowpass_setting_i, .output_upper_limit_i, .output_lower_limit_i, .output_scale_factor_i,
    .maximum_output_frequency_i, .prestart_frequency_i, .prestart_exit_level_i, .prestart_fail_delay_i,
    .sleep_entry_delay_i, .sleep_entry_frequency_i, .wake_threshold_i, .wake_criterion_select_i,
    .display_unit_select_i, .display_unit_gain_i, .display_unit_scale_i, .terminal_i,
    .terminal_function_assign_i, .frequency_command_o, .regulating_o, .sleeping_o, .prestart_failure_trip_o,
    .display_output_o, .display_unit_o);

  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic ticks(input int n);
    step(n * 25);
  endtask

  task automatic chk_f(input logic [15:0] exp, input int tol);
    checked++;
    if (({1'b0, frequency_command_o} + tol >= exp) && (frequency_command_o <= exp + tol)) begin
    end else begin
      failures++;
      $display("Error at %0t: frequency %0d, expected %0d", $time, frequency_command_o, exp);
    end
  endtask

  task automatic chk_b(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic base();
    application_mode_i = 3'h2; reference_source_select_i = 4'h0; keypad_reference_value_i = 16'sh1388;
    external_reference_i = 16'sh0000; target = 16'sh0000; slew = 8'h00; loop_proportional_gain_i = 14'h3E8;
    proportional_gain_scale_i = 10'h3E8; alternate_gain_value_i = 14'h3E8; loop_integral_time_i = 9'h000;
    loop_derivative_time_i = 10'h000; feed_forward_gain_i = 14'h000; output_lowpass_setting_i = 14'h000;
    output_upper_limit_i = 16'h1770; output_lower_limit_i = 16'h0000; output_scale_factor_i = 14'h3E8;
    maximum_output_frequency_i = 16'h1770; prestart_frequency_i = 16'h0000; prestart_exit_level_i = 16'h0000;
    prestart_fail_delay_i = 14'h001; sleep_entry_delay_i = 14'h000; sleep_entry_frequency_i = 16'h0000;
    wake_threshold_i = 16'h0000; wake_criterion_select_i = 2'h3; display_unit_select_i = 4'h0;
    display_unit_gain_i = 16'h03E8; display_unit_scale_i = 2'h2; terminal_i = 11'h000;
  endtask

  task automatic restart();
    run_i = 1'b0;
    step(2);
    run_i = 1'b1;
  endtask

  task automatic t_gains();
    base(); restart(); ticks(3);
    chk_f(16'h0BB8, 2);
    proportional_gain_scale_i = 10'h1F4; ticks(3);
    chk_f(16'h05DC, 2);
    proportional_gain_scale_i = 10'h3E8; alternate_gain_value_i = 14'h578; terminal_i = 11'h004; ticks(3);
    chk_f(16'h1068, 2);
    terminal_i = 11'h000; output_scale_factor_i = 14'h1F4; ticks(3);
    chk_f(16'h05DC, 2);
    output_scale_factor_i = 14'h3E8; output_upper_limit_i = 16'h07D0; ticks(3);
    chk_f(16'h07D0, 0);
    output_upper_limit_i = 16'h1770; output_lower_limit_i = 16'h04B0; target = 16'sh1F40; ticks(3);
    chk_f(16'h04B0, 0);
  endtask

  task automatic t_ffwd();
    base(); loop_proportional_gain_i = 14'h000; feed_forward_gain_i = 14'h0C8; restart(); ticks(3);
    chk_f(16'h0258, 2);
    reference_source_select_i = 4'h1; external_reference_i = 16'sh09C4; ticks(3);
    chk_f(16'h012C, 2);
  endtask

  task automatic t_integ();
    base(); loop_proportional_gain_i = 14'h000; loop_integral_time_i = 9'h00A; restart(); ticks(1000);
    chk_f(16'h0BB8, 20);
    terminal_i = 11'h001; ticks(4);
    chk_f(16'h0000, 2);
  endtask

  task automatic t_bypass();
    base(); restart(); ticks(3);
    chk_b(regulating_o, 1'b1);
    terminal_i = 11'h002; ticks(2);
    chk_b(regulating_o, 1'b0);
    chk_f(16'h0BB8, 2);
    terminal_i = 11'h000; ticks(2);
    chk_b(regulating_o, 1'b1);
    application_mode_i = 3'h0; restart(); ticks(3);
    chk_b(regulating_o, 1'b0);
  endtask

  task automatic t_prestart();
    base(); loop_proportional_gain_i = 14'h000; prestart_frequency_i = 16'h0BB8;
    prestart_exit_level_i = 16'h07D0; restart(); ticks(3);
    chk_f(16'h0BB8, 0);
    chk_b(regulating_o, 1'b0);
    target = 16'sh09C4; slew = 8'h20; ticks(6);
    chk_b(regulating_o, 1'b1);
    target = 16'sh0000; slew = 8'h00; restart(); ticks(990);
    chk_b(prestart_failure_trip_o, 1'b0);
    ticks(20);
    chk_b(prestart_failure_trip_o, 1'b1);
    chk_f(16'h0000, 0);
    run_i = 1'b0; step(2);
    chk_b(prestart_failure_trip_o, 1'b0);
    chk_f(16'h0000, 0);
  endtask

  task automatic t_sleep();
    for (int m = 0; m < 3; m++) begin
      base(); sleep_entry_frequency_i = 16'h03E8; sleep_entry_delay_i = 14'h001; wake_threshold_i = 16'h0BB8;
      wake_criterion_select_i = m[1:0]; keypad_reference_value_i = fb_sleep[m]; target = fb_sleep[m];
      restart(); ticks(90);
      chk_b(sleeping_o, 1'b0);
      ticks(20);
      chk_b(sleeping_o, 1'b1);
      chk_f(16'h0000, 0);
      target = fb_wake[m]; ticks(3);
      chk_b(sleeping_o, 1'b0);
    end
  endtask

  task automatic t_display();
    display_unit_scale_i = 2'h1; display_unit_select_i = 4'h5; ticks(2);
    checked++;
    if (display_output_o !== 32'sd400) begin
      failures++;
      $display("Error at %0t: display output %0d", $time, display_output_o);
    end
    checked++;
    if (display_unit_o !== 4'h5) begin
      failures++;
      $display("Error at %0t: display unit %0d", $time, display_unit_o);
    end
    display_unit_select_i = 4'hD; ticks(2);
    checked++;
    if (display_unit_o !== 4'h0) begin
      failures++;
      $display("Error at %0t: display unit %0d", $time, display_unit_o);
    end
  endtask

  task automatic t_filter();
    base(); output_lowpass_setting_i = 14'h3E8; restart(); ticks(3);
    chk_f(16'h05DC, 2);
    base(); loop_proportional_gain_i = 14'h000; loop_derivative_time_i = 10'h064; target = 16'sh2710;
    restart(); ticks(3);
    slew = 8'h01; target = 16'sh0000; ticks(4);
    chk_f(16'h05DC, 2);
  endtask

  task automatic finish_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    base();
    step(5);
    sys_rst_i = 1'b0;
    chk_f(16'h0000, 0);
    chk_b(regulating_o, 1'b0);
    t_gains();
    t_ffwd();
    t_integ();
    t_bypass();
    t_prestart();
    t_sleep();
    t_display();
    t_filter();
    finish_test();
  end

  initial begin
    #4000000;
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire

// ===== include/plr_pkg.sv
package plr_pkg;
  typedef enum logic [2:0] {
    PLR_IDLE  = 3'b000,
    PLR_PRE   = 3'b001,
    PLR_RUN   = 3'b010,
    PLR_SLEEP = 3'b011,
    PLR_TRIP  = 3'b100
  } plr_state_t;
  typedef logic signed [31:0] plr_word_t;
endpackage

// ===== include/plr_regs.svh
`ifndef PLR_REGS_SVH
`define PLR_REGS_SVH
`define PLR_CLK_HZ          25000000
`define PLR_TICK_US         1000
`define PLR_TICK_CYC        ((`PLR_CLK_HZ / 1000000) * `PLR_TICK_US)
`define PLR_TICKS_PER_S     1000
`define PLR_FN_ITERM_CLEAR  6'h15
`define PLR_FN_OPENLOOP     6'h16
`define PLR_FN_GAIN2        6'h17
`define PLR_MODE_PROC       3'h2
`define PLR_SRC_KEYPAD      4'h0
`define PLR_WAKE_BELOW      2'h0
`define PLR_WAKE_ABOVE      2'h1
`define PLR_WAKE_BEYOND     2'h2
`define PLR_UNIT_MAX        4'hC
`define PLR_FULL            32'sh00002710
`define PLR_SAT_MAX         32'sh00FFFFFF
`define PLR_SAT_MIN         (-32'sh00FFFFFF)
`endif

// ===== logic/plr_sync.sv
`default_nettype none
module plr_sync #(
  parameter int W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;
  always_comb begin
    out_d = out_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s2_q[i];
      end
    end
  end
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q  <= async_i;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end
  assign sync_o = out_q;
endmodule
`default_nettype wire

// ===== logic/plr_top.sv
`include "plr_regs.svh"
`default_nettype none
module plr_top
  import plr_pkg::*;
#(
  parameter int NTERM    = 11,
  parameter int TICK_CYC = `PLR_TICK_CYC
) (
  // Clock and reset
  input  wire logic                clock_i,
  input  wire logic                sys_rst_i,
  // Run control
  input  wire logic                run_i,
  input  wire logic [2:0]          application_mode_i,
  // Reference and feedback, 0.01 percent units
  input  wire logic [3:0]          reference_source_select_i,
  input  wire logic signed [15:0]  keypad_reference_value_i,
  input  wire logic signed [15:0]  external_reference_i,
  input  wire logic signed [15:0]  feedback_i,
  // Tuning, 0.1 percent / 0.1 s / ms units
  input  wire logic [13:0]         loop_proportional_gain_i,
  input  wire logic [9:0]          proportional_gain_scale_i,
  input  wire logic [13:0]         alternate_gain_value_i,
  input  wire logic [8:0]          loop_integral_time_i,
  input  wire logic [9:0]          loop_derivative_time_i,
  input  wire logic [13:0]         feed_forward_gain_i,
  input  wire logic [13:0]         output_lowpass_setting_i,
  input  wire logic [15:0]         output_upper_limit_i,
  input  wire logic [15:0]         output_lower_limit_i,
  input  wire logic [13:0]         output_scale_factor_i,
  input  wire logic [15:0]         maximum_output_frequency_i,
  // Prestart and sleep, 0.01 Hz / 0.01 percent / s / 0.1 s
  input  wire logic [15:0]         prestart_frequency_i,
  input  wire logic [15:0]         prestart_exit_level_i,
  input  wire logic [13:0]         prestart_fail_delay_i,
  input  wire logic [13:0]         sleep_entry_delay_i,
  input  wire logic [15:0]         sleep_entry_frequency_i,
  input  wire logic [15:0]         wake_threshold_i,
  input  wire logic [1:0]          wake_criterion_select_i,
  // Display
  input  wire logic [3:0]          display_unit_select_i,
  input  wire logic [15:0]         display_unit_gain_i,
  input  wire logic [1:0]          display_unit_scale_i,
  // Multi-function terminals
  input  wire logic [NTERM-1:0]    terminal_i,
  input  wire logic [NTERM*6-1:0]  terminal_function_assign_i,
  // Outputs
  output logic [15:0]              frequency_command_o,
  output logic                     regulating_o,
  output logic                     sleeping_o,
  output logic                     prestart_failure_trip_o,
  output logic signed [31:0]       display_output_o,
  output logic [3:0]               display_unit_o
);
  logic [NTERM-1:0] term_s;
  plr_sync #(.W(NTERM)) u_sync (
    .clock_i  (clock_i),
    .sys_rst_i(sys_rst_i),
    .async_i  (terminal_i),
    .sync_o   (term_s)
  );

  function automatic plr_word_t sat(input logic signed [63:0] v);
    if (v > 64'(`PLR_SAT_MAX)) begin
      return `PLR_SAT_MAX;
    end else if (v < 64'(`PLR_SAT_MIN)) begin
      return `PLR_SAT_MIN;
    end
    return v[31:0];
  endfunction

  logic clr_in, bypass_in, gain2_in;
  always_comb begin
    clr_in    = 1'b0;
    bypass_in = 1'b0;
    gain2_in  = 1'b0;
    for (int i = 0; i < NTERM; i++) begin
      if (term_s[i] && terminal_function_assign_i[i*6 +: 6] == `PLR_FN_ITERM_CLEAR) clr_in = 1'b1;
      if (term_s[i] && terminal_function_assign_i[i*6 +: 6] == `PLR_FN_OPENLOOP) bypass_in = 1'b1;
      if (term_s[i] && terminal_function_assign_i[i*6 +: 6] == `PLR_FN_GAIN2) gain2_in = 1'b1;
    end
  end

  // Sample tick divider
  logic [31:0] div_q, div_d;
  logic        tick;
  always_comb begin
    tick  = (div_q == 32'(TICK_CYC - 1));
    div_d = tick ? 32'h0 : div_q + 32'h1;
  end

  plr_word_t ref_w, fb_w, err_w;
  always_comb begin
    ref_w = (reference_source_select_i == `PLR_SRC_KEYPAD) ? 32'(keypad_reference_value_i)
                                                            : 32'(external_reference_i);
    fb_w  = 32'(feedback_i);
    err_w = ref_w - fb_w;
  end

  plr_state_t  st_q, st_d;
  plr_word_t   integ_q, integ_d, prev_err_q, prev_err_d, filt_q, filt_d;
  logic [31:0] tmr_q, tmr_d;
  logic [15:0] freq_q, freq_d;
  logic        trip_q, trip_d;
  plr_word_t   disp_q, disp_d;

  plr_word_t        p_term, d_term, ff_term, raw, out_pct;
  logic signed [63:0] gain_eff, tmp;
  logic [15:0]      reg_freq, pct_freq;
  logic             mode_ok;
  logic [31:0]      lim_hi, lim_lo;
  always_comb begin
    mode_ok  = (application_mode_i == `PLR_MODE_PROC);
    gain_eff = gain2_in ? 64'(alternate_gain_value_i) : 64'(loop_proportional_gain_i);
    // Gain in 0.1 percent, scale in 0.1 percent
    tmp      = 64'(err_w) * gain_eff * $signed(64'(proportional_gain_scale_i)) / 64'sd1000000;
    p_term   = sat(tmp);
    // Derivative: Td[ms] * de per tick / tick length
    tmp      = 64'(err_w - prev_err_q) * $signed(64'(loop_derivative_time_i)) / 64'(`PLR_TICK_US / 1000);
    d_term   = sat(tmp);
    tmp      = 64'(ref_w) * $signed(64'(feed_forward_gain_i)) / 64'sd1000;
    ff_term  = sat(tmp);
    raw      = sat(64'(p_term) + 64'(integ_q / 64'(`PLR_TICKS_PER_S)) + 64'(d_term) + 64'(ff_term));
    // Limits in 0.01 Hz converted to 0.01 percent of maximum
    // Upper limit rounded up so the converted frequency can reach it
    lim_hi   = (maximum_output_frequency_i == 16'h0) ? 32'h0 :
               32'((64'(output_upper_limit_i) * 64'sd10000 + 64'(maximum_output_frequency_i) - 64'sd1) /
                   64'(maximum_output_frequency_i));
    lim_lo   = (maximum_output_frequency_i == 16'h0) ? 32'h0 :
               32'(64'(output_lower_limit_i) * 64'sd10000 / 64'(maximum_output_frequency_i));
    tmp      = 64'(filt_q) * $signed(64'(output_scale_factor_i)) / 64'sd1000;
    out_pct  = sat(tmp);
    if (out_pct > $signed(lim_hi)) out_pct = lim_hi;
    if (out_pct < $signed(lim_lo)) out_pct = lim_lo;
    if (out_pct < 0) out_pct = 32'sh0;
    tmp      = 64'(out_pct) * 64'(maximum_output_frequency_i) / 64'(`PLR_FULL);
    pct_freq = (tmp > 64'sh0000FFFF) ? 16'hFFFF : tmp[15:0];
    if (pct_freq > output_upper_limit_i) pct_freq = output_upper_limit_i;
    if (pct_freq < output_lower_limit_i) pct_freq = output_lower_limit_i;
    reg_freq = pct_freq;
  end

  logic wake;
  logic signed [63:0] dtmp;
  always_comb begin
    unique case (wake_criterion_select_i)
      `PLR_WAKE_BELOW: wake = fb_w < $signed(32'(wake_threshold_i));
      `PLR_WAKE_ABOVE: wake = fb_w > $signed(32'(wake_threshold_i));
      `PLR_WAKE_BEYOND: wake = err_w > $signed(32'(wake_threshold_i));
      default: wake = 1'b0;
    endcase
  end

  always_comb begin
    st_d       = st_q;
    dtmp       = 64'sh0;
    integ_d    = integ_q;
    prev_err_d = prev_err_q;
    filt_d     = filt_q;
    tmr_d      = tmr_q;
    freq_d     = freq_q;
    trip_d     = trip_q;
    disp_d     = disp_q;
    if (!run_i) begin
      st_d = PLR_IDLE;
      integ_d = 32'sh0;
      prev_err_d = 32'sh0;
      filt_d = 32'sh0;
      tmr_d = 32'h0;
      freq_d = 16'h0;
      trip_d = 1'b0;
    end else if (tick) begin
      // Display scaled by unit gain, divided by 1, 10 or 100
      dtmp = 64'(out_pct) * $signed(64'(display_unit_gain_i)) / 64'sd1000;
      disp_d = sat(dtmp / ((display_unit_scale_i == 2'h0) ? 64'sd100 :
                          (display_unit_scale_i == 2'h1) ? 64'sd10 : 64'sd1));
      unique case (st_q)
        PLR_IDLE: begin
          tmr_d = 32'h0;
          if (mode_ok && prestart_frequency_i != 16'h0) begin
            st_d   = PLR_PRE;
            freq_d = prestart_frequency_i;
          end else begin
            st_d = PLR_RUN;
          end
        end
        PLR_PRE: begin
          freq_d = prestart_frequency_i;
          if (fb_w > $signed(32'(prestart_exit_level_i))) begin
            st_d = PLR_RUN;
            tmr_d = 32'h0;
          end else if (tmr_q >= 32'(prestart_fail_delay_i) * 32'(`PLR_TICKS_PER_S)) begin
            st_d = PLR_TRIP;
            trip_d = 1'b1;
            freq_d = 16'h0;
          end else begin
            tmr_d = tmr_q + 32'h1;
          end
        end
        PLR_RUN: begin
          if (!mode_ok || bypass_in) begin
            freq_d = pct_freq;
            integ_d = 32'sh0;
            filt_d = raw;
            tmr_d = 32'h0;
          end else begin
            if (clr_in || loop_integral_time_i == 9'h0) integ_d = 32'sh0;
            else integ_d = sat(64'(integ_q) + 64'(err_w) * 64'sd10 / $signed(64'(loop_integral_time_i)));
            prev_err_d = err_w;
            filt_d = sat(64'(filt_q) + (64'(raw) - 64'(filt_q)) * 64'sd1000 /
                         (64'sd1000 + $signed(64'(output_lowpass_setting_i))));
            freq_d = reg_freq;
            if (freq_q < sleep_entry_frequency_i) begin
              if (tmr_q >= 32'(sleep_entry_delay_i) * 32'(`PLR_TICKS_PER_S / 10)) begin
                st_d = PLR_SLEEP;
                freq_d = 16'h0;
              end else begin
                tmr_d = tmr_q + 32'h1;
              end
            end else begin
              tmr_d = 32'h0;
            end
          end
        end
        PLR_SLEEP: begin
          freq_d = 16'h0;
          tmr_d = 32'h0;
          if (wake) st_d = PLR_RUN;
        end
        PLR_TRIP: begin
          freq_d = 16'h0;
        end
        default: st_d = PLR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      div_q      <= 32'h0;
      st_q       <= PLR_IDLE;
      integ_q    <= 32'sh0;
      prev_err_q <= 32'sh0;
      filt_q     <= 32'sh0;
      tmr_q      <= 32'h0;
      freq_q     <= 16'h0;
      trip_q     <= 1'b0;
      disp_q     <= 32'sh0;
    end else begin
      div_q      <= div_d;
      st_q       <= st_d;
      integ_q    <= integ_d;
      prev_err_q <= prev_err_d;
      filt_q     <= filt_d;
      tmr_q      <= tmr_d;
      freq_q     <= freq_d;
      trip_q     <= trip_d;
      disp_q     <= disp_d;
    end
  end

  logic [3:0] unit_q;
  logic       reg_q, slp_q;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      unit_q <= 4'h0;
      reg_q  <= 1'b0;
      slp_q  <= 1'b0;
    end else begin
      unit_q <= (display_unit_select_i > `PLR_UNIT_MAX) ? 4'h0 : display_unit_select_i;
      reg_q  <= (st_d == PLR_RUN) && mode_ok && !bypass_in;
      slp_q  <= (st_d == PLR_SLEEP);
    end
  end

  assign frequency_command_o     = freq_q;
  assign regulating_o            = reg_q;
  assign sleeping_o              = slp_q;
  assign prestart_failure_trip_o = trip_q;
  assign display_output_o        = disp_q;
  assign display_unit_o          = unit_q;

  a_trip_zero_freq: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    trip_q |-> freq_q == 16'h0) else $error("trip with nonzero frequency");
  a_sleep_zero_freq: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    st_q == PLR_SLEEP |-> freq_q == 16'h0) else $error("sleep with nonzero frequency");
  a_stop_idle: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !run_i |=> st_q == PLR_IDLE && integ_q == 0) else $error("stop did not clear");
  a_clear_integ: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    run_i && tick && st_q == PLR_RUN && clr_in |=> integ_q == 0) else $error("integral not cleared");
  a_pre_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    st_q == PLR_PRE && $past(st_q) == PLR_PRE && run_i |-> freq_q == prestart_frequency_i || trip_q)
    else $error("prestart frequency not held");
  a_tick_period: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    tick |=> !tick) else $error("tick too frequent");
  a_mode_gate: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    regulating_o |-> $past(mode_ok)) else $error("regulating outside process mode");
  a_bypass_gate: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    bypass_in |=> !regulating_o) else $error("regulating while bypassed");
endmodule
`default_nettype wire
